// >>> ecl_regs.vh
// register indices, field positions and error codes of the error code log queue
`ifndef ECL_REGS_VH
`define ECL_REGS_VH
`define ECL_IDX_STATUS 8'h00
`define ECL_IDX_ERRPOP 8'h0A
`define ECL_STAT_ERR_BIT 13
`define ECL_DEPTH 5'h10
`define ECL_PTR_MAX 4'hF
`define ECL_PTR_ZERO 4'h0
`define ECL_PTR_ONE 4'h1
`define ECL_COUNT_ZERO 5'h00
`define ECL_COUNT_ONE 5'h01
`define ECL_CODE_NONE 8'h00
`define ECL_CODE_BADCMD 8'h06
`define ECL_CODE_SERIAL 8'h0B
`define ECL_CODE_BAUD 8'h12
`define ECL_CODE_DSP 8'h25
`define ECL_CODE_OVFL 8'h2D
`define ECL_CODE_FLASH 8'h2E
`endif

// >>> ecl_error_log.v
// error code log queue with status word and pop-on-read
`timescale 1ns/10ps
`include "ecl_regs.vh"
module ecl_error_log (
  input wire clock,
  input wire rst,
  input wire readReq,
  input wire [7:0] parameterIndex,
  input wire [15:0] statusOther,
  input wire badCommand,
  input wire rxFault,
  input wire badBaud,
  input wire dspLoadFail,
  input wire checksumFail,
  input wire extErrValid,
  input wire [7:0] extErrCode,
  output reg readValid,
  output reg [15:0] readData,
  output reg errorPending
);

// ----------------------------------------
// event selection
// ----------------------------------------
// one push per cycle; simultaneous events are kept by holding them pending
reg [5:0] pendEv_q;
reg [7:0] extCode_q;
wire [5:0] evNow = pendEv_q | {extErrValid, checksumFail, dspLoadFail, badBaud, rxFault, badCommand};
reg [5:0] grant;
reg [7:0] pushCode;

always @* begin
  grant = 6'h00;
  pushCode = `ECL_CODE_NONE;
  if (evNow[0]) begin
    grant = 6'h01;
    pushCode = `ECL_CODE_BADCMD;
  end else if (evNow[1]) begin
    grant = 6'h02;
    pushCode = `ECL_CODE_SERIAL;
  end else if (evNow[2]) begin
    grant = 6'h04;
    pushCode = `ECL_CODE_BAUD;
  end else if (evNow[3]) begin
    grant = 6'h08;
    pushCode = `ECL_CODE_DSP;
  end else if (evNow[4]) begin
    grant = 6'h10;
    pushCode = `ECL_CODE_FLASH;
  end else if (evNow[5]) begin
    grant = 6'h20;
    pushCode = pendEv_q[5] ? extCode_q : extErrCode;
  end
end

// ----------------------------------------
// queue storage
// ----------------------------------------
reg [7:0] mem [0:15];
reg [3:0] rdPtr_q;
reg [3:0] wrPtr_q;
reg [4:0] count_q;
reg overflow_q;
integer i;

// ----------------------------------------
// request and event decode
// ----------------------------------------
wire popStat = readReq && parameterIndex == `ECL_IDX_STATUS;
wire popReq = readReq && parameterIndex == `ECL_IDX_ERRPOP;
wire unknownParam = readReq && !popStat && !popReq;
wire queueEmpty = count_q == `ECL_COUNT_ZERO;
wire full = count_q == `ECL_DEPTH;
wire push = grant != 6'h00;
wire doPop = popReq && !queueEmpty;
// a pop frees a slot, so a push in the same cycle still lands when full
wire doWrite = push && (!full || doPop);

function [3:0] nextPtr;
  input [3:0] p;
  begin
    nextPtr = (p == `ECL_PTR_MAX) ? `ECL_PTR_ZERO : p + `ECL_PTR_ONE;
  end
endfunction

// ----------------------------------------
// next state
// ----------------------------------------
reg [5:0] pendEv_d;
reg [7:0] extCode_d;
reg [3:0] rdPtr_d;
reg [3:0] wrPtr_d;
reg [4:0] count_d;
reg overflow_d;

always @* begin
  // an unknown index is logged one cycle later, through the pending set
  pendEv_d = (evNow & ~grant) | {5'h00, unknownParam};
  extCode_d = extCode_q;
  if (extErrValid && !pendEv_q[5]) begin
    extCode_d = extErrCode;
  end
end

always @* begin
  wrPtr_d = wrPtr_q;
  rdPtr_d = rdPtr_q;
  if (doWrite) begin
    wrPtr_d = nextPtr(wrPtr_q);
  end
  if (doPop) begin
    rdPtr_d = nextPtr(rdPtr_q);
  end
end

always @* begin
  count_d = count_q;
  if (doWrite && !doPop) begin
    count_d = count_q + `ECL_COUNT_ONE;
  end else if (doPop && !doWrite) begin
    count_d = count_q - `ECL_COUNT_ONE;
  end
end

always @* begin
  // newest codes dropped once full; the marker outlives the kept codes
  overflow_d = overflow_q;
  if (push && full && !doPop) begin
    overflow_d = 1'b1;
  end else if (popReq && queueEmpty) begin
    overflow_d = 1'b0;
  end
end

wire pending_d = (count_d != `ECL_COUNT_ZERO) || overflow_d;

// ----------------------------------------
// answer selection
// ----------------------------------------
reg [15:0] readData_d;

always @* begin
  readData_d = {8'h00, `ECL_CODE_NONE};
  if (popStat) begin
    // status bit shows the flag as it stood when the request was taken
    readData_d = statusOther;
    readData_d[`ECL_STAT_ERR_BIT] = errorPending;
  end else if (doPop) begin
    readData_d = {8'h00, mem[rdPtr_q]};
  end else if (popReq && overflow_q) begin
    readData_d = {8'h00, `ECL_CODE_OVFL};
  end
end

// ----------------------------------------
// event hold registers
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    pendEv_q <= 6'h00;
    extCode_q <= `ECL_CODE_NONE;
  end else begin
    pendEv_q <= pendEv_d;
    extCode_q <= extCode_d;
  end
end

// ----------------------------------------
// queue control registers
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    rdPtr_q <= `ECL_PTR_ZERO;
    wrPtr_q <= `ECL_PTR_ZERO;
    count_q <= `ECL_COUNT_ZERO;
    overflow_q <= 1'b0;
  end else begin
    rdPtr_q <= rdPtr_d;
    wrPtr_q <= wrPtr_d;
    count_q <= count_d;
    overflow_q <= overflow_d;
  end
end

// ----------------------------------------
// code memory
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    for (i = 0; i < `ECL_DEPTH; i = i + 1) begin
      mem[i] <= `ECL_CODE_NONE;
    end
  end else begin
    if (doWrite) begin
      mem[wrPtr_q] <= pushCode;
    end
  end
end

// ----------------------------------------
// host read answers
// ----------------------------------------
always @(posedge clock or posedge rst) begin
  if (rst) begin
    readValid <= 1'b0;
    readData <= 16'h0000;
    errorPending <= 1'b0;
  end else begin
    readValid <= readReq;
    readData <= readData_d;
    errorPending <= pending_d;
  end
end

endmodule

// >>> ecl_checker.sv
// port assertions for the error log
`timescale 1ns/10ps
module ecl_checker (
  input wire clock,
  input wire rst,
  input wire readReq,
  input wire [7:0] parameterIndex,
  input wire badCommand,
  input wire readValid,
  input wire [15:0] readData,
  input wire errorPending
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence popReq; readReq && parameterIndex == 8'h0A; endsequence
  a_answer_next: assert property (readReq |=> readValid) else $error("late");
  a_no_stray: assert property (!readReq |=> !readValid) else $error("stray");
  a_status_flag: assert property (readReq && parameterIndex == 8'h00 |=>
    readData[13] == $past(errorPending)) else $error("flag bit");
  a_pop_byte: assert property (popReq |=> readData[15:8] == 8'h00) else $error("wide");
  a_empty_zero: assert property (popReq ##0 !errorPending |=> readData == 16'h0000) else $error("empty");
  a_bad_index: assert property (readReq && parameterIndex != 8'h00 && parameterIndex != 8'h0A |=>
    readData == 16'h0000 ##[1:3] errorPending) else $error("index");
  a_flag_set: assert property (badCommand |=> errorPending) else $error("no flag");
  a_flag_hold: assert property (errorPending && !readReq |=> errorPending) else $error("drop");
endmodule
bind ecl_error_log ecl_checker u_chk (.clock(clock), .rst(rst), .readReq(readReq), .parameterIndex(parameterIndex),
  .badCommand(badCommand), .readValid(readValid), .readData(readData), .errorPending(errorPending));

// >>> ecl_host.sv
// host model sending parameter reads
`timescale 1ns/10ps
module ecl_host (
  input wire clock,
  input wire [15:0] readData,
  output logic readReq = 1'b0,
  output logic [7:0] parameterIndex = 8'h00
);
  // answer is fixed one cycle after the request edge
  task automatic rd(input logic [7:0] idx, output logic [15:0] d);
    @(posedge clock) #1;
    readReq = 1'b1;
    parameterIndex = idx;
    @(posedge clock) #1;
    readReq = 1'b0;
    parameterIndex = ~idx;
    d = readData;
  endtask
endmodule

// >>> tb.sv
// bench with a queue model of the error log
`timescale 1ns/10ps
module tb;
  localparam int CYC_LIMIT = 400;
  logic clock = 0, rst = 1, ovf = 0, extErrValid = 0, badCommand = 0, rxFault = 0, badBaud = 0;
  logic dspLoadFail = 0, checksumFail = 0;
  logic [7:0] lfsr = 8'h5C, extErrCode = 8'h00, e, q[$];
  logic [7:0] code [6] = '{8'h06, 8'h0B, 8'h12, 8'h25, 8'h2E, 8'h00};
  logic [15:0] d, statusOther = 16'h0000;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  wire readReq, readValid, errorPending;
  wire [7:0] parameterIndex;
  wire [15:0] readData;
  ecl_error_log u_dut (.clock(clock), .rst(rst), .readReq(readReq), .parameterIndex(parameterIndex),
    .statusOther(statusOther), .badCommand(badCommand), .rxFault(rxFault), .badBaud(badBaud),
    .dspLoadFail(dspLoadFail), .checksumFail(checksumFail), .extErrValid(extErrValid),
    .extErrCode(extErrCode), .readValid(readValid), .readData(readData), .errorPending(errorPending));
  ecl_host u_host (.clock(clock), .readData(readData), .readReq(readReq), .parameterIndex(parameterIndex));
  always #2.5 clock = ~clock;
  always @(posedge clock) if (++cyc == CYC_LIMIT) complete_run();
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [15:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("BAD %s expected %h seen %h", what, exp, seen);
  endtask
  // events in one mask land in the queue lowest bit first
  task automatic push(input logic [5:0] mask);
    @(posedge clock) #1;
    lfsr = lfsr_next(lfsr);
    code[5] = lfsr | 8'h01;
    statusOther = {lfsr, ~lfsr};
    extErrCode = code[5];
    {extErrValid, checksumFail, dspLoadFail, badBaud, rxFault, badCommand} = mask;
    @(posedge clock) #1;
    {extErrValid, checksumFail, dspLoadFail, badBaud, rxFault, badCommand} = 6'h00;
    for (int k = 0; k < 6; k++) begin
      if (mask[k] && q.size() < 16) q.push_back(code[k]);
      else if (mask[k]) ovf = 1;
    end
  endtask
  task automatic status(input logic [15:0] other);
    statusOther = other;
    u_host.rd(8'h00, d);
    chk(d, (other & 16'hDFFF) | {2'b00, q.size() > 0 || ovf, 13'h0000}, "status");
  endtask
  task automatic pop();
    e = ovf ? 8'h2D : 8'h00;
    if (q.size() > 0) e = q.pop_front();
    else ovf = 0;
    u_host.rd(8'h0A, d);
    chk(readValid, 1, "valid");
    chk(d, {8'h00, e}, "code");
    chk(errorPending, q.size() > 0 || ovf, "pending");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    #1 rst = 0;
    status(16'h0000);
    for (int i = 0; i < 18; i++) push(6'h01 << (i % 6));
    status({lfsr, ~lfsr});
    repeat (18) pop();
    $display("overflow test done");
    u_host.rd(8'h33, d);
    chk(d, 16'h0000, "bad index");
    q.push_back(8'h06);
    repeat (2) pop();
    $display("bad index test done");
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      push(lfsr[5:0] | 6'h11);
      repeat (6) @(posedge clock);
      status({lfsr, ~lfsr} | 16'h2000);
      while (q.size() > 0) pop();
      pop();
      status(16'hFFFF);
    end
    $display("simultaneous event test done");
    for (int i = 0; i < 3; i++) push(6'h01 << i);
    @(posedge clock) #1 rst = 1;
    q.delete();
    ovf = 0;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    status(16'h2000);
    pop();
    $display("reset test done");
    complete_run();
  end
  task automatic complete_run();
    if (cyc >= CYC_LIMIT) error_cnt++;
    $display("compared %0d bad %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule
